/* hw/serial_port_irq_dma_pkg.sv */
package serial_port_irq_dma_pkg;

  // =====================================================================
  // register page and index (byte address = index * 4)
  localparam logic [7:0] PAGE_UNIT0 = 8'h18;
  localparam logic [7:0] PAGE_UNIT1 = 8'h19;
  localparam logic [7:0] IDX_RX_CNT_PTR = 8'hF0;
  localparam logic [7:0] IDX_RX_ADDR_PTR = 8'hF1;
  localparam logic [7:0] IDX_TX_CNT_PTR = 8'hF2;
  localparam logic [7:0] IDX_TX_ADDR_PTR = 8'hF3;
  localparam logic [7:0] IDX_IRQ_VECTOR = 8'hF4;
  localparam logic [7:0] IDX_ADDR_COMPARE = 8'hF5;
  localparam logic [7:0] IDX_IRQ_MASK = 8'hF6;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'hF7;
  localparam logic [7:0] IDX_DATA_BUFFER = 8'hF8;
  localparam logic [7:0] IDX_IRQ_DMA_PRIO = 8'hF9;
  localparam logic [7:0] IDX_CHAR_CONFIG = 8'hFA;
  localparam logic [7:0] IDX_CLOCK_CONFIG = 8'hFB;
  localparam logic [7:0] IDX_BAUD_HIGH = 8'hFC;
  localparam logic [7:0] IDX_BAUD_LOW = 8'hFD;
  localparam logic [7:0] IDX_SYNC_IN_CTRL = 8'hFE;
  localparam logic [7:0] IDX_SYNC_OUT_CTRL = 8'hFF;

  // =====================================================================
  // irq_mask fields
  localparam int IMR_TX_EMPTY_SRC = 7;
  localparam int IMR_RX_EOB = 6;
  localparam int IMR_TX_EOB = 5;
  localparam int IMR_RX_ERR = 4;
  localparam int IMR_RX_ADDR = 3;
  localparam int IMR_RX_BRK = 2;
  localparam int IMR_RX_DATA = 1;
  localparam int IMR_TX_DATA = 0;

  // irq_status fields
  localparam int ISR_OVERRUN = 7;
  localparam int ISR_FRAMING = 6;
  localparam int ISR_PARITY = 5;
  localparam int ISR_ADDR = 4;
  localparam int ISR_BREAK = 3;
  localparam int ISR_RX_DATA = 2;
  localparam int ISR_TX_BUF_EMPTY = 1;
  localparam int ISR_TX_SHIFT_EMPTY = 0;

  // irq_dma_priority fields
  localparam int IRQ_DMA_PRIORITY_CHAR_SEARCH = 2;
  localparam int IRQ_DMA_PRIORITY_RX_DMA_EN = 1;
  localparam int IRQ_DMA_PRIORITY_TX_DMA_EN = 0;

  // pointer register bit 0 selectors
  localparam int PTR_SEL_BIT = 0;

  // encoded vector bits
  localparam logic [1:0] EV_RX_ERROR = 2'h0;
  localparam logic [1:0] EV_BRK_ADDR = 2'h1;
  localparam logic [1:0] EV_RX_DATA = 2'h2;
  localparam logic [1:0] EV_TX = 2'h3;

  localparam logic [7:0] REG_RESET = 8'h00;

  typedef struct packed {
    logic wait_n;
    logic [7:0] rdata;
    logic [7:0] rx_cnt_ptr;
    logic [7:0] rx_addr_ptr;
    logic [7:0] tx_cnt_ptr;
    logic [7:0] tx_addr_ptr;
    logic [4:0] vec_base;
    logic [1:0] vec_code;
    logic [7:0] addr_compare;
    logic [7:0] irq_mask;
    logic [7:0] irq_status;
    logic [7:0] rx_buf;
    logic [7:0] tx_buf;
    logic [7:0] irq_dma_priority;
    logic [7:0] char_config;
    logic [7:0] clock_config;
    logic [7:0] baud_high;
    logic [7:0] baud_low;
    logic [7:0] sync_in;
    logic [7:0] sync_out;
    logic rx_pend;
    logic tx_pend;
    logic tx_armed;
    logic dma_req;
    logic dma_is_tx;
    logic [7:0] dma_cnt_ptr;
    logic [7:0] dma_addr_ptr;
    logic irq;
    logic tx_load;
  } state_t;

endpackage

/* hw/serial_port_irq_dma_ctrl.sv */
`timescale 1ns/10ps
// Overview of operation
// - tx irq source: buffer empty or shift empty
// - rx irqs: data, errors, address, break
// - four levels encoded into two vector bits
// - priority: rx dma, tx dma, rx irq, tx irq
// - vector codes 110, 100, 010, 000
// - separate receive and transmit dma channels
// - rx dma starts on received character
// - tx dma starts on transmit buffer empty, once a buffer write has armed it
// - dma replaces data/shift irqs with end-of-block
// - last dma byte sets end-of-block flag
// - receive error stops receive dma
// - search match not transferred, dma continues
// - counter pointer: address 7:1, space bit 0
// - address pointer bit 0 selects extension
// - unit registers on page 18h or 19h
// - receive/transmit buffers share index F8h
// - data irq masks never gate dma
module serial_port_irq_dma_ctrl
  import serial_port_irq_dma_pkg::*;
#(
  parameter bit UNIT_SEL = 1'b0
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic [17:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_rx_char_done,
  input wire logic [7:0] i_rx_char,
  input wire logic i_rx_framing_err,
  input wire logic i_rx_parity_err,
  input wire logic i_rx_addr_match,
  input wire logic i_rx_break,
  input wire logic i_tx_buf_empty,
  input wire logic i_tx_shift_empty,
  output logic [7:0] o_tx_data,
  output logic o_tx_load,
  output logic o_dma_req,
  output logic o_dma_is_tx,
  output logic [7:0] o_dma_cnt_ptr,
  output logic [7:0] o_dma_addr_ptr,
  output logic [7:0] o_dma_wdata,
  input wire logic i_dma_ack,
  input wire logic i_dma_last,
  input wire logic [7:0] i_dma_rdata,
  output logic o_irq,
  output logic [7:0] o_irq_vector
);

  // every register starts at zero so software always sees a known state
  localparam state_t RESET_S = '{
    wait_n: 1'b0,
    rdata: REG_RESET,
    rx_cnt_ptr: REG_RESET,
    rx_addr_ptr: REG_RESET,
    tx_cnt_ptr: REG_RESET,
    tx_addr_ptr: REG_RESET,
    vec_base: 5'h00,
    vec_code: EV_RX_ERROR,
    addr_compare: REG_RESET,
    irq_mask: REG_RESET,
    irq_status: REG_RESET,
    rx_buf: REG_RESET,
    tx_buf: REG_RESET,
    irq_dma_priority: REG_RESET,
    char_config: REG_RESET,
    clock_config: REG_RESET,
    baud_high: REG_RESET,
    baud_low: REG_RESET,
    sync_in: REG_RESET,
    sync_out: REG_RESET,
    rx_pend: 1'b0,
    tx_pend: 1'b0,
    tx_armed: 1'b0,
    dma_req: 1'b0,
    dma_is_tx: 1'b0,
    dma_cnt_ptr: REG_RESET,
    dma_addr_ptr: REG_RESET,
    irq: 1'b0,
    tx_load: 1'b0
  };

  state_t s_q;
  state_t s_d;

  logic [7:0] page;
  logic [7:0] idx;
  logic hit;
  logic req;
  logic done;
  logic [7:0] wr;
  logic wr_en;
  logic rd_done;
  logic rx_dma_en;
  logic tx_dma_en;
  logic rx_err_any;
  logic search_hit;
  logic src_err;
  logic src_brk;
  logic src_rx;
  logic src_tx;
  logic any_int;
  logic [7:0] rd_mux;
  logic rd_buf;
  logic rx_take;

  // =====================================================================
  // register bus decode
  assign page = i_avs_address[17:10];
  assign idx = i_avs_address[9:2];
  assign hit = (page == (UNIT_SEL ? PAGE_UNIT1 : PAGE_UNIT0));
  assign req = i_avs_read | i_avs_write;
  // the request completes on the edge where waitrequest is seen low
  assign done = req & s_q.wait_n;
  assign wr = i_avs_writedata[7:0];
  assign wr_en = done & i_avs_write & i_avs_byteenable[0] & hit;
  assign rd_done = done & i_avs_read & hit;
  assign rx_dma_en = s_q.irq_dma_priority[IRQ_DMA_PRIORITY_RX_DMA_EN];
  assign tx_dma_en = s_q.irq_dma_priority[IRQ_DMA_PRIORITY_TX_DMA_EN];
  assign rx_err_any = |s_q.irq_status[ISR_OVERRUN:ISR_PARITY];
  assign search_hit = s_q.irq_dma_priority[IRQ_DMA_PRIORITY_CHAR_SEARCH]
                      & i_rx_addr_match;
  assign rd_buf = rd_done & (idx == IDX_DATA_BUFFER);
  // a character that software takes itself is never moved again by dma,
  // so a stopped receive channel resumes with the next character only
  assign rx_take = s_q.rx_pend & ~rd_buf;

  // =====================================================================
  // interrupt sources after masking
  assign src_err = s_q.irq_mask[IMR_RX_ERR] & rx_err_any;
  assign src_brk = (s_q.irq_mask[IMR_RX_ADDR] & s_q.irq_status[ISR_ADDR])
                 | (s_q.irq_mask[IMR_RX_BRK] & s_q.irq_status[ISR_BREAK]);

  // end-of-block stays a source after the enable drops at block end
  always_comb begin
    if (rx_dma_en || s_q.irq_mask[IMR_RX_EOB]) begin
      src_rx = s_q.irq_mask[IMR_RX_DATA]
               & s_q.irq_mask[IMR_RX_EOB];
    end else begin
      src_rx = s_q.irq_mask[IMR_RX_DATA] & s_q.irq_status[ISR_RX_DATA];
    end
    if (tx_dma_en || s_q.irq_mask[IMR_TX_EOB]) begin
      src_tx = s_q.irq_mask[IMR_TX_DATA]
               & s_q.irq_mask[IMR_TX_EOB];
    end else if (s_q.irq_mask[IMR_TX_EMPTY_SRC]) begin
      src_tx = s_q.irq_mask[IMR_TX_DATA]
               & s_q.irq_status[ISR_TX_BUF_EMPTY];
    end else begin
      src_tx = s_q.irq_mask[IMR_TX_DATA]
               & s_q.irq_status[ISR_TX_SHIFT_EMPTY];
    end
  end
  assign any_int = src_err | src_brk | src_rx | src_tx;

  // =====================================================================
  // register read mux
  always_comb begin
    case (idx)
      IDX_RX_CNT_PTR: rd_mux = s_q.rx_cnt_ptr;
      IDX_RX_ADDR_PTR: rd_mux = s_q.rx_addr_ptr;
      IDX_TX_CNT_PTR: rd_mux = s_q.tx_cnt_ptr;
      IDX_TX_ADDR_PTR: rd_mux = s_q.tx_addr_ptr;
      IDX_IRQ_VECTOR: rd_mux = {s_q.vec_base, s_q.vec_code, 1'b0};
      IDX_ADDR_COMPARE: rd_mux = s_q.addr_compare;
      IDX_IRQ_MASK: rd_mux = s_q.irq_mask;
      IDX_IRQ_STATUS: rd_mux = s_q.irq_status;
      IDX_DATA_BUFFER: rd_mux = s_q.rx_buf;
      IDX_IRQ_DMA_PRIO: rd_mux = s_q.irq_dma_priority;
      IDX_CHAR_CONFIG: rd_mux = s_q.char_config;
      IDX_CLOCK_CONFIG: rd_mux = s_q.clock_config;
      IDX_BAUD_HIGH: rd_mux = s_q.baud_high;
      IDX_BAUD_LOW: rd_mux = s_q.baud_low;
      IDX_SYNC_IN_CTRL: rd_mux = s_q.sync_in;
      IDX_SYNC_OUT_CTRL: rd_mux = s_q.sync_out;
      default: rd_mux = REG_RESET;
    endcase
  end

  // =====================================================================
  // next state
  always_comb begin
    s_d = s_q;
    s_d.tx_load = 1'b0;
    // waitrequest drops for exactly one cycle per request
    // one wait state keeps read data registered; each access costs two
    s_d.wait_n = req & ~s_q.wait_n;
    if (req && !s_q.wait_n) begin
      s_d.rdata = hit ? rd_mux : REG_RESET;
    end

    // =================================================================
    // software writes: flags can only be cleared
    if (wr_en) begin
      case (idx)
        IDX_RX_CNT_PTR: s_d.rx_cnt_ptr = wr;
        IDX_RX_ADDR_PTR: s_d.rx_addr_ptr = wr;
        IDX_TX_CNT_PTR: s_d.tx_cnt_ptr = wr;
        IDX_TX_ADDR_PTR: s_d.tx_addr_ptr = wr;
        IDX_IRQ_VECTOR: s_d.vec_base = wr[7:3];
        IDX_ADDR_COMPARE: s_d.addr_compare = wr;
        IDX_IRQ_MASK: begin
          s_d.irq_mask = wr;
          s_d.irq_mask[IMR_RX_EOB] = s_q.irq_mask[IMR_RX_EOB]
                                     & wr[IMR_RX_EOB];
          s_d.irq_mask[IMR_TX_EOB] = s_q.irq_mask[IMR_TX_EOB]
                                     & wr[IMR_TX_EOB];
        end
        IDX_IRQ_STATUS: s_d.irq_status = s_q.irq_status & wr;
        IDX_DATA_BUFFER: begin
          s_d.tx_buf = wr;
          s_d.tx_load = 1'b1;
          // the write only arms: this byte leaves first, dma feeds the rest
          s_d.tx_armed = tx_dma_en;
        end
        IDX_IRQ_DMA_PRIO: s_d.irq_dma_priority = wr;
        IDX_CHAR_CONFIG: s_d.char_config = wr;
        IDX_CLOCK_CONFIG: s_d.clock_config = wr;
        IDX_BAUD_HIGH: s_d.baud_high = wr;
        IDX_BAUD_LOW: s_d.baud_low = wr;
        IDX_SYNC_IN_CTRL: s_d.sync_in = wr;
        IDX_SYNC_OUT_CTRL: s_d.sync_out = wr;
        default: s_d.rdata = s_d.rdata;
      endcase
    end
    // reading the receive buffer consumes the pending character
    if (rd_buf) begin
      s_d.irq_status[ISR_RX_DATA] = 1'b0;
      s_d.rx_pend = 1'b0;
    end

    // =================================================================
    // dma completion
    if (s_q.dma_req && i_dma_ack) begin
      s_d.dma_req = 1'b0;
      if (s_q.dma_is_tx) begin
        s_d.tx_buf = i_dma_rdata;
        s_d.tx_load = 1'b1;
        s_d.tx_pend = 1'b0;
        if (i_dma_last) begin
          s_d.irq_mask[IMR_TX_EOB] = 1'b1;
          s_d.irq_dma_priority[IRQ_DMA_PRIORITY_TX_DMA_EN] = 1'b0;
          s_d.tx_armed = 1'b0;
        end
      end else begin
        s_d.rx_pend = 1'b0;
        s_d.irq_status[ISR_RX_DATA] = 1'b0;
        if (i_dma_last) begin
          s_d.irq_mask[IMR_RX_EOB] = 1'b1;
          s_d.irq_dma_priority[IRQ_DMA_PRIORITY_RX_DMA_EN] = 1'b0;
        end
      end
    end

    // =================================================================
    // hardware events: set wins over a same-cycle clear
    if (i_rx_char_done) begin
      s_d.rx_buf = i_rx_char;
      // overrun: previous character neither read nor moved by dma
      if (s_q.irq_status[ISR_RX_DATA] || s_q.rx_pend) begin
        s_d.irq_status[ISR_OVERRUN] = 1'b1;
      end
      if (i_rx_framing_err) begin
        s_d.irq_status[ISR_FRAMING] = 1'b1;
      end
      if (i_rx_parity_err) begin
        s_d.irq_status[ISR_PARITY] = 1'b1;
      end
      s_d.irq_status[ISR_RX_DATA] = 1'b1;
      if (rx_dma_en && !search_hit) begin
        s_d.rx_pend = 1'b1;
      end
    end
    if (i_rx_addr_match) begin
      s_d.irq_status[ISR_ADDR] = 1'b1;
    end
    if (i_rx_break) begin
      s_d.irq_status[ISR_BREAK] = 1'b1;
    end
    if (i_tx_buf_empty) begin
      s_d.irq_status[ISR_TX_BUF_EMPTY] = 1'b1;
      if (s_d.tx_armed && tx_dma_en) begin
        s_d.tx_pend = 1'b1;
      end
    end
    if (i_tx_shift_empty) begin
      s_d.irq_status[ISR_TX_SHIFT_EMPTY] = 1'b1;
    end

    // =================================================================
    // dma arbitration: receive before transmit
    // a pending receive error holds receive dma off until cleared
    // a new request waits one cycle after an acknowledge, so the core
    // always sees the request line drop between two transfers
    if (!s_q.dma_req) begin
      if (rx_take && rx_dma_en && !rx_err_any) begin
        s_d.dma_req = 1'b1;
        s_d.dma_is_tx = 1'b0;
        s_d.dma_cnt_ptr = s_q.rx_cnt_ptr;
        s_d.dma_addr_ptr = s_q.rx_addr_ptr;
      end else if (s_q.tx_pend && tx_dma_en) begin
        s_d.dma_req = 1'b1;
        s_d.dma_is_tx = 1'b1;
        s_d.dma_cnt_ptr = s_q.tx_cnt_ptr;
        s_d.dma_addr_ptr = s_q.tx_addr_ptr;
      end
    end

    // =================================================================
    // interrupt: yields to any dma request
    // the code is kept while no source stands, so a late read of the
    // vector still shows the last cause
    s_d.irq = any_int & ~s_d.dma_req;
    if (src_err) begin
      s_d.vec_code = EV_RX_ERROR;
    end else if (src_brk) begin
      s_d.vec_code = EV_BRK_ADDR;
    end else if (src_rx) begin
      s_d.vec_code = EV_RX_DATA;
    end else if (src_tx) begin
      s_d.vec_code = EV_TX;
    end
  end

  // =====================================================================
  // state register
  // synchronous reset only: bus, dma and event inputs share this clock
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      s_q <= RESET_S;
    end else begin
      s_q <= s_d;
    end
  end

  // =====================================================================
  // outputs
  assign o_avs_readdata = {24'h000000, s_q.rdata};
  assign o_avs_waitrequest = ~s_q.wait_n;
  assign o_tx_data = s_q.tx_buf;
  assign o_tx_load = s_q.tx_load;
  assign o_dma_req = s_q.dma_req;
  assign o_dma_is_tx = s_q.dma_is_tx;
  assign o_dma_cnt_ptr = s_q.dma_cnt_ptr;
  assign o_dma_addr_ptr = s_q.dma_addr_ptr;
  assign o_dma_wdata = s_q.rx_buf;
  assign o_irq = s_q.irq;
  assign o_irq_vector = {s_q.vec_base, s_q.vec_code, 1'b0};

endmodule

/* verification/dma_core_model.sv */
`timescale 1ns/10ps
// =====================================================================
// dma bus responder: acks each request after 0..3 idle cycles
module dma_core_model (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_req,
  input wire logic [7:0] i_next_data,
  input wire logic i_last_en,
  output logic o_ack,
  output logic o_last,
  output logic [7:0] o_rdata
);
  int wait_n;
  always_ff @(posedge i_sys_clk) begin
    o_ack <= 1'b0;
    o_last <= 1'b0;
    // released data bus toggles so a stale byte is never mistaken
    o_rdata <= ~o_rdata;
    if (i_rst) begin
      wait_n <= 0;
      o_rdata <= 8'h5A;
    end else if (i_req && !o_ack) begin
      if (wait_n == 0) begin
        o_ack <= 1'b1;
        o_last <= i_last_en;
        o_rdata <= i_next_data;
        wait_n <= $urandom_range(0, 3);
      end else begin
        wait_n <= wait_n - 1;
      end
    end
  end
endmodule

/* verification/serial_port_irq_dma_ctrl_sva.sv */
`timescale 1ns/10ps
// =====================================================================
// port checks
module serial_port_irq_dma_ctrl_sva (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic o_avs_waitrequest,
  input wire logic [31:0] o_avs_readdata,
  input wire logic [7:0] o_tx_data,
  input wire logic o_tx_load,
  input wire logic o_dma_req,
  input wire logic o_dma_is_tx,
  input wire logic [7:0] o_dma_cnt_ptr,
  input wire logic [7:0] o_dma_addr_ptr,
  input wire logic i_dma_ack,
  input wire logic [7:0] i_dma_rdata,
  input wire logic i_rx_char_done,
  input wire logic i_rx_framing_err,
  input wire logic o_irq,
  input wire logic [7:0] o_irq_vector
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  property p_ans;
    (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest;
  endproperty
  a_ans: assert property (p_ans) else $error("bus not answered");
  property p_one;
    !o_avs_waitrequest |=> o_avs_waitrequest;
  endproperty
  a_one: assert property (p_one) else $error("answer too long");
  property p_rdhi;
    !o_avs_waitrequest |-> o_avs_readdata[31:8] == 24'h0;
  endproperty
  a_rdhi: assert property (p_rdhi) else $error("read upper bits");
  property p_vec0;
    o_irq_vector[0] == 1'b0;
  endproperty
  a_vec0: assert property (p_vec0) else $error("vector bit 0 set");
  property p_hold;
    o_dma_req && !i_dma_ack |=> o_dma_req && $stable(o_dma_is_tx)
      && $stable(o_dma_cnt_ptr) && $stable(o_dma_addr_ptr);
  endproperty
  a_hold: assert property (p_hold) else $error("dma request moved");
  property p_drop;
    o_dma_req && i_dma_ack |=> !o_dma_req;
  endproperty
  a_drop: assert property (p_drop) else $error("dma request kept");
  property p_prio;
    o_dma_req |-> !o_irq;
  endproperty
  a_prio: assert property (p_prio) else $error("irq beside dma");
  property p_load;
    o_dma_req && o_dma_is_tx && i_dma_ack |=>
      o_tx_load && o_tx_data == $past(i_dma_rdata);
  endproperty
  a_load: assert property (p_load) else $error("tx byte not loaded");
  property p_pulse;
    o_tx_load |=> !o_tx_load;
  endproperty
  a_pulse: assert property (p_pulse) else $error("tx load too long");
  property p_err;
    i_rx_char_done && i_rx_framing_err && !o_dma_req |=>
      !(o_dma_req && !o_dma_is_tx) [*4];
  endproperty
  a_err: assert property (p_err) else $error("rx dma after error");
endmodule
bind serial_port_irq_dma_ctrl serial_port_irq_dma_ctrl_sva u_sva (
  .i_sys_clk, .i_rst, .i_avs_read, .i_avs_write, .o_avs_waitrequest,
  .o_avs_readdata, .o_tx_data, .o_tx_load, .o_dma_req, .o_dma_is_tx,
  .o_dma_cnt_ptr, .o_dma_addr_ptr, .i_dma_ack, .i_dma_rdata,
  .i_rx_char_done, .i_rx_framing_err, .o_irq, .o_irq_vector);

/* verification/serial_port_irq_dma_ctrl_tb.sv */
`timescale 1ns/10ps
module serial_port_irq_dma_ctrl_tb;
  import serial_port_irq_dma_pkg::*;
  logic clk = 1'b0, rst = 1'b1, av_rd = 1'b0, av_wr = 1'b0, rx_done = 1'b0;
  logic fe = 1'b0, pe = 1'b0, am = 1'b0, brk = 1'b0, tbe = 1'b0, tse = 1'b0;
  logic last_en = 1'b0;
  logic [17:0] av_addr = '0;
  logic [31:0] av_wd = '0;
  logic [7:0] rx_char = '0, nxt = '0, v, c, d, cp, ap, cp2, ap2;
  logic [7:0] rw[10] = '{8'hF0, 8'hF1, 8'hF2, 8'hF3, 8'hF5, 8'hFA, 8'hFB,
    8'hFC, 8'hFD, 8'hFF};
  wire [31:0] rdata;
  wire wreq, tx_load, dreq, dtx, irq, ack, dlast;
  wire [7:0] tx_data, dcnt, daddr, dwd, vec, drd;
  int fail_count = 0, n_tests = 0, cyc = 0;
  logic [7:0] rq[$], tq[$];
  logic [24:0] dq[$];
  always #25 clk = ~clk;
  serial_port_irq_dma_ctrl uut (.i_sys_clk(clk), .i_rst(rst),
    .i_avs_address(av_addr), .i_avs_read(av_rd), .i_avs_write(av_wr),
    .i_avs_writedata(av_wd), .i_avs_byteenable(4'hF),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
    .i_rx_char_done(rx_done), .i_rx_char(rx_char), .i_rx_framing_err(fe),
    .i_rx_parity_err(pe), .i_rx_addr_match(am), .i_rx_break(brk),
    .i_tx_buf_empty(tbe), .i_tx_shift_empty(tse), .o_tx_data(tx_data),
    .o_tx_load(tx_load), .o_dma_req(dreq), .o_dma_is_tx(dtx),
    .o_dma_cnt_ptr(dcnt), .o_dma_addr_ptr(daddr), .o_dma_wdata(dwd),
    .i_dma_ack(ack), .i_dma_last(dlast), .i_dma_rdata(drd), .o_irq(irq),
    .o_irq_vector(vec));
  dma_core_model u_core (.i_sys_clk(clk), .i_rst(rst), .i_req(dreq),
    .i_next_data(nxt), .i_last_en(last_en), .o_ack(ack), .o_last(dlast),
    .o_rdata(drd));
  // =====================================================================
  // tasks
  task automatic chk(input string nm, input logic [24:0] e, g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic print_verdict();
    if (fail_count == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] x);
    av_rd <= !w;
    av_wr <= w;
    av_addr <= {a, 2'b00};
    av_wd <= {24'($urandom), x};
    @(posedge clk);
    while (wreq !== 1'b0) @(posedge clk);
    av_rd <= 1'b0;
    av_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] i, x);
    bus(1'b1, {PAGE_UNIT0, i}, x);
  endtask
  task automatic rd(input logic [7:0] i, e);
    rq.push_back(e);
    bus(1'b0, {PAGE_UNIT0, i}, 8'h00);
  endtask
  task automatic rx(input logic [7:0] x, input logic [3:0] fl);
    rx_done <= 1'b1;
    rx_char <= x;
    {fe, pe, am, tbe} <= fl;
    @(posedge clk);
    {rx_done, fe, pe, am, tbe} <= '0;
    repeat (10) @(posedge clk);
  endtask
  task automatic ev(input logic [2:0] k);
    {brk, tbe, tse} <= k;
    @(posedge clk);
    {brk, tbe, tse} <= '0;
    repeat (10) @(posedge clk);
  endtask
  task automatic irq_chk(input logic on, input logic [1:0] code);
    @(negedge clk);
    chk("irq", {24'h0, on}, {24'h0, irq});
    if (on) chk("vector", {17'h0, 5'h15, code, 1'b0}, {17'h0, vec});
    @(posedge clk);
  endtask
  // =====================================================================
  // result watcher: results are matched against the oldest note
  always @(negedge clk) begin
    if (av_rd && wreq === 1'b0)
      chk("readdata", rq.size() ? rq.pop_front() : 'x, rdata[7:0]);
    if (tx_load === 1'b1)
      chk("tx_data", tq.size() ? tq.pop_front() : 'x, tx_data);
    if (dreq === 1'b1 && ack === 1'b1)
      chk("dma", dq.size() ? dq.pop_front() : 'x,
        {dtx, dcnt, daddr, dtx ? 8'h00 : dwd});
    cyc++;
    if (cyc > 6000) begin
      fail_count++;
      print_verdict();
    end
  end
  initial begin
    void'($urandom(77));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 240; i < 256; i++) if (i != 244) rd(8'(i), 8'h00);
    foreach (rw[k]) begin
      v = $urandom;
      wr(rw[k], v);
      rd(rw[k], v);
    end
    bus(1'b1, {PAGE_UNIT1, IDX_SYNC_OUT_CTRL}, ~v);
    rd(IDX_SYNC_OUT_CTRL, v);
    wr(IDX_IRQ_VECTOR, 8'hAF);
    wr(IDX_IRQ_MASK, 8'h9F);
    ev(3'b010);
    irq_chk(1'b1, EV_TX);
    ev(3'b100);
    irq_chk(1'b1, EV_BRK_ADDR);
    rx(8'h3C, 4'b0100);
    irq_chk(1'b1, EV_RX_ERROR);
    rd(IDX_IRQ_STATUS, 8'h2E);
    rd(IDX_DATA_BUFFER, 8'h3C);
    wr(IDX_IRQ_STATUS, 8'hDF);
    rd(IDX_IRQ_STATUS, 8'h0A);
    irq_chk(1'b1, EV_BRK_ADDR);
    wr(IDX_IRQ_STATUS, 8'h00);
    wr(IDX_IRQ_STATUS, 8'hFF);
    rd(IDX_IRQ_STATUS, 8'h00);
    wr(IDX_IRQ_MASK, 8'h1F);
    ev(3'b010);
    irq_chk(1'b0, EV_TX);
    ev(3'b001);
    irq_chk(1'b1, EV_TX);
    wr(IDX_IRQ_STATUS, 8'h00);
    rx(8'h11, 4'b0000);
    irq_chk(1'b1, EV_RX_DATA);
    rd(IDX_DATA_BUFFER, 8'h11);
    // masks off: dma must still run
    wr(IDX_IRQ_MASK, 8'h00);
    cp = $urandom;
    ap = $urandom;
    wr(IDX_RX_CNT_PTR, cp);
    wr(IDX_RX_ADDR_PTR, ap);
    wr(IDX_IRQ_DMA_PRIO, 8'h02);
    for (int k = 0; k < 2; k++) begin
      c = $urandom;
      last_en <= k[0];
      dq.push_back({1'b0, cp, ap, c});
      rx(c, 4'b0000);
    end
    rd(IDX_IRQ_MASK, 8'h40);
    rd(IDX_IRQ_DMA_PRIO, 8'h00);
    wr(IDX_IRQ_MASK, 8'h42);
    irq_chk(1'b1, EV_RX_DATA);
    wr(IDX_IRQ_MASK, 8'h00);
    last_en <= 1'b0;
    wr(IDX_IRQ_DMA_PRIO, 8'h02);
    rx(8'h55, 4'b1000);
    rd(IDX_IRQ_STATUS, 8'h44);
    rd(IDX_DATA_BUFFER, 8'h55);
    wr(IDX_IRQ_STATUS, 8'hBF);
    c = $urandom;
    dq.push_back({1'b0, cp, ap, c});
    rx(c, 4'b0000);
    wr(IDX_IRQ_DMA_PRIO, 8'h06);
    rx(8'hA5, 4'b0010);
    rd(IDX_DATA_BUFFER, 8'hA5);
    wr(IDX_IRQ_STATUS, 8'h00);
    c = $urandom;
    dq.push_back({1'b0, cp, ap, c});
    rx(c, 4'b0000);
    cp2 = $urandom;
    ap2 = $urandom;
    wr(IDX_TX_CNT_PTR, cp2);
    wr(IDX_TX_ADDR_PTR, ap2);
    wr(IDX_IRQ_DMA_PRIO, 8'h03);
    tq.push_back(8'hD1);
    wr(IDX_DATA_BUFFER, 8'hD1);
    d = $urandom;
    c = $urandom;
    nxt <= d;
    dq.push_back({1'b0, cp, ap, c});
    dq.push_back({1'b1, cp2, ap2, 8'h00});
    tq.push_back(d);
    rx(c, 4'b0001);
    while (tq.size() != 0) @(posedge clk);
    d = $urandom;
    nxt <= d;
    last_en <= 1'b1;
    dq.push_back({1'b1, cp2, ap2, 8'h00});
    tq.push_back(d);
    ev(3'b010);
    rd(IDX_IRQ_MASK, 8'h20);
    rd(IDX_IRQ_DMA_PRIO, 8'h02);
    ev(3'b010);
    wr(IDX_TX_CNT_PTR, cp2);
    wr(IDX_TX_ADDR_PTR, ap2);
    wr(IDX_IRQ_STATUS, 8'hFE);
    wr(IDX_IRQ_MASK, 8'h00);
    wr(IDX_IRQ_DMA_PRIO, 8'h03);
    tq.push_back(8'h3E);
    wr(IDX_DATA_BUFFER, 8'h3E);
    d = $urandom;
    nxt <= d;
    last_en <= 1'b0;
    dq.push_back({1'b1, cp2, ap2, 8'h00});
    tq.push_back(d);
    ev(3'b010);
    rd(IDX_IRQ_DMA_PRIO, 8'h03);
    rd(IDX_IRQ_MASK, 8'h00);
    repeat (10) @(posedge clk);
    print_verdict();
  end
endmodule
